//--- design/sar_pkg.sv
// Shared constants for the successive-approximation conversion sequencer
package sar_pkg;
  localparam int unsigned RESULT_W = 16;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODE_FULL_SCALE = 16'hFFFF;
  localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
  localparam logic [15:0] CODE_MSB = 16'h8000;
  // Acquisition time in ns and its cycle count at 125 MHz (least time, rounded up)
  localparam int unsigned ACQ_TIME_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ACQ_CYCLES_W = 8'(ACQ_CYCLES);
  localparam logic [7:0] ACQ_COUNT_RESET = 8'h00;
  localparam logic [4:0] BIT_INDEX_MSB = 5'h0F;
  typedef enum logic [4:0] {
    ST_ACQUIRE = 5'b00001,
    ST_WAIT    = 5'b00010,
    ST_HOLD    = 5'b00100,
    ST_TRIAL   = 5'b01000,
    ST_FORMAT  = 5'b10000
  } seq_state_t;
endpackage

//--- design/sar_result_reg.sv
// Result holding register with registered read data
`timescale 1ns/1ns
module sar_result_reg (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_load,
  input  wire logic [15:0] i_word,
  output logic      [15:0] o_word
);
  logic [15:0] word_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      word_reg <= sar_pkg::RESULT_RESET;
    end else if (i_load) begin
      word_reg <= i_word;
    end
  end
  assign o_word = word_reg;
endmodule // sar_result_reg

//--- design/sar_conversion_sequencer.sv
// Control sequencer of a 16-bit successive-approximation converter
`timescale 1ns/1ns
module sar_conversion_sequencer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_conversion_start_n,
  input  wire logic        i_coding_select,
  input  wire logic        i_power_down_in,
  input  wire logic        i_comparator_high,
  input  wire logic        i_over_range,
  input  wire logic        i_under_range,
  output logic             o_busy,
  output logic             o_array_common_switch,
  output logic             o_sample_hold,
  output logic      [15:0] o_array_bits,
  output logic      [15:0] o_result
);
  // Pins from outside the clock domain pass three flops; a change counts once stages two and three agree
  // Bit order of the pin vectors from bit 0 up: start, coding, power-down, over-range, under-range
  wire [4:0] pin_raw  = {i_under_range, i_over_range, i_power_down_in, i_coding_select, i_conversion_start_n};
  // Start idles high, so its stages reset high and reset leaves no false falling edge
  wire [4:0] pin_idle = 5'h01;
  wire [4:0] pin_level;

  genvar idx;
  generate
    for (idx = 0; idx < 5; idx++) begin : g_pin_sync
      logic [2:0] stage_reg;
      logic       level_reg;
      always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
          stage_reg <= {3{pin_idle[idx]}};
          level_reg <= pin_idle[idx];
        end else begin
          stage_reg <= {stage_reg[1:0], pin_raw[idx]};
          // A level seen by one stage only is ignored, which filters one-cycle glitches
          if (stage_reg[2] == stage_reg[1]) begin
            level_reg <= stage_reg[2];
          end
        end
      end
      assign pin_level[idx] = level_reg;
    end
  endgenerate

  wire start_n_lvl = pin_level[0];
  wire coding_lvl  = pin_level[1];
  wire pd_lvl      = pin_level[2];
  wire over_lvl    = pin_level[3];
  wire under_lvl   = pin_level[4];

  logic start_prev_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      start_prev_reg <= 1'b1;
    end else begin
      start_prev_reg <= start_n_lvl;
    end
  end

  sar_pkg::seq_state_t state_reg, state_next;
  logic [7:0]  acq_count_reg;
  logic [4:0]  bit_index_reg;
  logic [15:0] trial_reg;
  logic [15:0] final_word_reg;
  logic        busy_reg, common_sw_reg, hold_reg, load_reg;
  logic        over_held_reg, under_held_reg;

  wire acq_done    = (acq_count_reg == sar_pkg::ACQ_CYCLES_W);
  wire start_fall  = start_prev_reg & ~start_n_lvl;
  wire start_ok    = acq_done & ~pd_lvl;
  wire last_bit    = (bit_index_reg == 5'h00);
  wire in_hold     = (state_reg == sar_pkg::ST_HOLD);
  wire in_trial    = (state_reg == sar_pkg::ST_TRIAL);
  wire load_result = (state_reg == sar_pkg::ST_FORMAT);
  wire enter_hold  = (state_next == sar_pkg::ST_HOLD);
  wire [15:0] bit_mask = 16'h0001 << bit_index_reg[3:0];
  // Comparator high means the trial weight overshoots, so that bit is released
  wire [15:0] trial_kept = i_comparator_high ? (trial_reg & ~bit_mask) : trial_reg;
  wire [15:0] next_trial = last_bit ? trial_kept : ((trial_kept) | (bit_mask >> 1));
  // The array shows each trial in the same cycle in which the comparator judges it
  wire [15:0] array_next = in_hold ? sar_pkg::CODE_MSB
                         : (in_trial && !last_bit) ? next_trial : 16'h0000;
  // Clamp flags are taken when the sample is held, so they stay with its own code
  wire [15:0] raw_code = over_held_reg ? sar_pkg::CODE_FULL_SCALE
                       : under_held_reg ? sar_pkg::CODE_ZERO_SCALE : final_word_reg;
  // Twos complement differs only by an inverted MSB
  wire [15:0] coded = coding_lvl ? raw_code : (raw_code ^ sar_pkg::CODE_MSB);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sar_pkg::ST_ACQUIRE: begin
        // A start held low through acquisition converts at once
        if (start_ok && !start_n_lvl) begin
          state_next = sar_pkg::ST_HOLD;
        end else if (start_ok) begin
          state_next = sar_pkg::ST_WAIT;
        end
      end
      sar_pkg::ST_WAIT: begin
        // Power-down may rise while waiting, so it is checked again here
        if (!pd_lvl && start_fall) begin
          state_next = sar_pkg::ST_HOLD;
        end
      end
      sar_pkg::ST_HOLD: begin
        state_next = sar_pkg::ST_TRIAL;
      end
      sar_pkg::ST_TRIAL: begin
        if (last_bit) begin
          state_next = sar_pkg::ST_FORMAT;
        end
      end
      sar_pkg::ST_FORMAT: begin
        state_next = sar_pkg::ST_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_reg <= sar_pkg::ST_ACQUIRE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      acq_count_reg <= sar_pkg::ACQ_COUNT_RESET;
    end else if (state_reg != sar_pkg::ST_ACQUIRE) begin
      acq_count_reg <= sar_pkg::ACQ_COUNT_RESET;
    end else if (!acq_done) begin
      acq_count_reg <= acq_count_reg + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      bit_index_reg  <= sar_pkg::BIT_INDEX_MSB;
      trial_reg      <= 16'h0000;
      final_word_reg <= 16'h0000;
    end else if (in_hold) begin
      bit_index_reg <= sar_pkg::BIT_INDEX_MSB;
      trial_reg     <= sar_pkg::CODE_MSB;
    end else if (in_trial) begin
      trial_reg <= next_trial;
      if (last_bit) begin
        final_word_reg <= trial_kept;
      end else begin
        bit_index_reg <= bit_index_reg - 5'h01;
      end
    end
  end

  // Range flags are captured on the edge that holds the sample
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      over_held_reg  <= 1'b0;
      under_held_reg <= 1'b0;
    end else if (enter_hold) begin
      over_held_reg  <= over_lvl;
      under_held_reg <= under_lvl;
    end
  end

  // Switch and hold controls are registered from the next state so they change together with the state
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      busy_reg      <= 1'b0;
      common_sw_reg <= 1'b1;
      hold_reg      <= 1'b0;
      load_reg      <= 1'b0;
    end else begin
      load_reg      <= load_result;
      common_sw_reg <= (state_next == sar_pkg::ST_ACQUIRE) || (state_next == sar_pkg::ST_WAIT);
      hold_reg      <= (state_next == sar_pkg::ST_HOLD) || (state_next == sar_pkg::ST_TRIAL)
                       || (state_next == sar_pkg::ST_FORMAT);
      // Busy falls only after the result register has taken the word
      if (enter_hold) begin
        busy_reg <= 1'b1;
      end else if (load_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Trial pattern to the switch array; zero whenever no trial is running
  logic [15:0] array_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      array_reg <= 16'h0000;
    end else begin
      array_reg <= array_next;
    end
  end

  sar_result_reg u_result (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_load    (load_result),
    .i_word    (coded),
    .o_word    (o_result)
  );

  assign o_busy                = busy_reg;
  assign o_array_common_switch = common_sw_reg;
  assign o_sample_hold         = hold_reg;
  assign o_array_bits          = array_reg;
endmodule // sar_conversion_sequencer

//--- verification/sar_conversion_sequencer_assertions.sv
// Port-level checks on the conversion sequencer
`timescale 1ns/1ns
module sar_conversion_sequencer_assertions (
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic        i_power_down_in,
  input wire logic        o_busy,
  input wire logic        o_array_common_switch,
  input wire logic        o_sample_hold,
  input wire logic [15:0] o_array_bits,
  input wire logic [15:0] o_result
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_start; $rose(o_busy); endsequence
  sequence s_finish; o_busy[*8] ##[8:16] !o_busy; endsequence
  a_start_holds: assert property (s_start |-> o_sample_hold && !o_array_common_switch)
    else $error("hold not entered at start");
  a_msb_first: assert property (s_start |-> ##[1:2] o_array_bits == 16'h8000)
    else $error("first trial is not the top bit");
  a_conv_length: assert property (s_start |-> s_finish)
    else $error("busy length out of range");
  a_result_in_busy: assert property ($changed(o_result) && $past(i_reset_n) |-> o_busy)
    else $error("result moved outside a conversion");
  a_busy_after_load: assert property ($changed(o_result) && $past(i_reset_n) |=> !o_busy)
    else $error("busy did not fall after the result was loaded");
  a_array_idle: assert property (!o_busy && !$past(o_busy) |-> o_array_bits == 16'h0000)
    else $error("trial bits set while idle");
  a_switch_idle: assert property (!o_busy && !$past(o_busy) |-> o_array_common_switch && !o_sample_hold)
    else $error("array not acquiring while idle");
  a_power_down: assert property (i_power_down_in[*8] |-> !$rose(o_busy))
    else $error("conversion started in power-down");
  a_reset_values: assert property (disable iff (1'b0) !i_reset_n |=> !o_busy && o_result == 16'h0000)
    else $error("reset values wrong");
endmodule // sar_conversion_sequencer_assertions

//--- verification/sar_host_model.sv
// Host and comparator model facing the sequencer
`timescale 1ns/1ns
module sar_host_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_go,
  input  wire logic        i_busy,
  input  wire logic [15:0] i_sample,
  input  wire logic [15:0] i_array_bits,
  output logic             o_start_n,
  output logic             o_comparator_high
);
  logic start_n_reg = 1'b1;
  // Start is held low until busy answers, so an early request waits out acquisition
  always @(posedge i_ref_clk) begin
    if (i_busy)
      start_n_reg <= #1 1'b1;
    else if (i_go)
      start_n_reg <= #1 1'b0;
  end
  assign o_start_n = start_n_reg;
  // A trial weight above the held sample is too large
  assign o_comparator_high = i_array_bits > i_sample;
endmodule // sar_host_model

//--- verification/sar_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module sar_conversion_sequencer_tb;
  logic        i_ref_clk       = 1'b0;
  logic        i_reset_n       = 1'b0;
  logic        i_coding_select = 1'b1;
  logic        i_power_down_in = 1'b0;
  logic        i_over_range    = 1'b0;
  logic        i_under_range   = 1'b0;
  logic        go              = 1'b0;
  logic [15:0] sample          = 16'h0000;
  logic [15:0] vals [4]        = '{16'h8000, 16'h7FFF, 16'h0001, 16'hFFFE};
  logic        start_n, cmp_high, o_busy, o_array_common_switch, o_sample_hold;
  logic [15:0] o_array_bits, o_result;
  int          miscompares     = 0;
  int          cmp_count       = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  sar_conversion_sequencer sar_conversion_sequencer_inst (.i_ref_clk, .i_reset_n, .i_conversion_start_n(start_n),
    .i_coding_select, .i_power_down_in, .i_comparator_high(cmp_high), .i_over_range, .i_under_range, .o_busy,
    .o_array_common_switch, .o_sample_hold, .o_array_bits, .o_result);
  sar_host_model sar_host_model_inst (.i_ref_clk, .i_go(go), .i_busy(o_busy), .i_sample(sample),
    .i_array_bits(o_array_bits), .o_start_n(start_n), .o_comparator_high(cmp_high));
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_busy(input logic level, input int limit);
    for (int n = 0; n < limit && o_busy !== level; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
    if (o_busy !== level) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic request();
    @(posedge i_ref_clk);
    #1 go = 1'b1;
    @(posedge i_ref_clk);
    #1 go = 1'b0;
  endtask
  // Clamp flags and coding are set well before the start, as the synchronisers need
  task automatic convert(input logic [15:0] v, input logic code, input logic ovr, input logic und, input int idle,
                         input logic pd);
    logic [15:0] exp;
    sample = v;
    i_coding_select = code;
    i_over_range = ovr;
    i_under_range = und;
    repeat (idle) @(posedge i_ref_clk);
    request();
    wait_busy(1'b1, 400);
    check("hold pins", {14'h0000, o_sample_hold, o_array_common_switch}, 16'h0002);
    i_power_down_in = pd;
    wait_busy(1'b0, 40);
    check("acquire pins", {14'h0000, o_sample_hold, o_array_common_switch}, 16'h0001);
    exp = ovr ? 16'hFFFF : und ? 16'h0000 : v;
    check("result", o_result, code ? exp : exp ^ 16'h8000);
  endtask
  initial begin
    repeat (12) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    // Idle 0 requests during acquisition, idle 140 waits for a falling edge
    for (int k = 0; k < 12; k++)
      convert(vals[(k >> 1) % 4], k[0], (k >> 1) == 4, (k >> 1) == 5, k[1] ? 140 : 0, 1'b0);
    convert(16'h1234, 1'b1, 1'b0, 1'b0, 140, 1'b1);
    request();
    repeat (300) begin
      @(posedge i_ref_clk);
      #1 check("busy", {15'h0000, o_busy}, 16'h0000);
    end
    i_power_down_in = 1'b0;
    wait_busy(1'b1, 400);
    repeat (5) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b0;
    @(posedge i_ref_clk);
    #1 check("reset result", o_result, 16'h0000);
    check("reset busy", {15'h0000, o_busy}, 16'h0000);
    i_reset_n = 1'b1;
    convert(16'h0F0F, 1'b0, 1'b0, 1'b0, 140, 1'b0);
    finish_test();
  end
endmodule // sar_conversion_sequencer_tb
bind sar_conversion_sequencer sar_conversion_sequencer_assertions sar_conversion_sequencer_assertions_inst (
  .i_ref_clk, .i_reset_n, .i_power_down_in, .o_busy, .o_array_common_switch, .o_sample_hold, .o_array_bits, .o_result);
